// >>> logic/cmr_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef CMR_DEFINES_VH
`define CMR_DEFINES_VH
// byte addresses of the AXI4-Lite register map
`define CMR_OFF_CTRL     8'h00
`define CMR_OFF_STAT     8'h04
`define CMR_OFF_CFG_A    8'h08
`define CMR_OFF_CFG_B    8'h0C
`define CMR_OFF_CFG_C    8'h10
`define CMR_OFF_TXRTS    8'h14
`define CMR_OFF_INTF     8'h18
`define CMR_OFF_INTE     8'h1C
`define CMR_OFF_ERRCNT   8'h20
`define CMR_OFF_CMD      8'h24
`define CMR_OFF_FILT     8'h28
`define CMR_OFF_RXCTRL   8'h2C
// field positions
`define CMR_REQ_HI       7
`define CMR_REQ_LO       5
`define CMR_WAKE_GLITCH_FILTER_EN_BIT   6
`define CMR_WAKE_FLAG_BIT    6
`define CMR_WAKE_ENABLE_BIT    6
`define CMR_RESET_BIT    0
// mode codes
`define CMR_MODE_NORMAL  3'h0
`define CMR_MODE_SLEEP   3'h1
`define CMR_MODE_LOOP    3'h2
`define CMR_MODE_LISTEN  3'h3
`define CMR_MODE_CONFIG  3'h4
// reset values
`define CMR_CTRL_RST     8'hE7
`define CMR_ZERO8        8'h00
// timing: start-up count in oscillator periods, glitch filter length
`define CMR_OST_TOSC     128
`define CMR_OST_CYC      8'd128
`define CMR_FILT_CYC     4'd4
`define CMR_AXI_OKAY     2'h0
`define CMR_AXI_SLVERR   2'h2
`endif

// >>> logic/cmr_mode_ctrl.v
// operating-mode and reset controller with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "cmr_defines.vh"
module cmr_mode_ctrl
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // external reset pin, active low, asynchronous to aclk
  input  wire        reset_pin_n,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // can bus pins
  input  wire        bus_rx_in,
  output reg         bus_tx_out,
  // protocol engine side
  input  wire        tx_pending,
  input  wire        engine_tx_bit,
  input  wire        tec_inc,
  input  wire        rec_inc,
  input  wire        rx_frame_done,
  output reg         rx_accept_en,
  output reg         loopback_en,
  output reg         ack_ignore,
  output reg         osc_run,
  output reg         wake_irq
);

////////////////////////////////////////////////////////////////////////////
// input synchronisers
reg [1:0] rst_sync_r;
reg [1:0] rx_sync_r;
always @(posedge aclk)
begin
  rst_sync_r <= {rst_sync_r[0], reset_pin_n};
  rx_sync_r  <= {rx_sync_r[0], bus_rx_in};
end
wire rx_s = rx_sync_r[1];

////////////////////////////////////////////////////////////////////////////
// registers and state
reg [7:0]  can_control_reg_r;
reg [2:0]  op_mode_status_field_r;
reg [7:0]  bit_timing_cfg_a_r;
reg [7:0]  bit_timing_cfg_b_r;
reg [7:0]  bit_timing_cfg_c_r;
reg [7:0]  tx_request_pin_ctrl_r;
reg [7:0]  interrupt_flag_reg_r;
reg [7:0]  interrupt_enable_reg_r;
reg [7:0]  tec_r;
reg [7:0]  rec_r;
reg [31:0] filter_mask_r;
reg [7:0]  rx_buffer_ctrl_r;
reg        soft_reset_r;
reg [7:0]  osc_startup_timer_r;
reg [3:0]  filt_cnt_r;
reg        rx_filt_r;
reg        rx_prev_r;
reg        discard_r;

localparam ST_RUN   = 3'b001;
localparam ST_SLEEP = 3'b010;
localparam ST_WAKE  = 3'b100;
reg [2:0] state_r;

// all three reset sources (aresetn, reset pin, soft reset) funnel into one internal reset
wire int_rst = !aresetn || !rst_sync_r[1] || soft_reset_r;

wire [2:0] mode_request_field =
  can_control_reg_r[`CMR_REQ_HI:`CMR_REQ_LO];
wire req_valid = (mode_request_field <= `CMR_MODE_CONFIG);
wire in_config = (op_mode_status_field_r == `CMR_MODE_CONFIG);
wire in_listen = (op_mode_status_field_r == `CMR_MODE_LISTEN);
wire in_normal = (op_mode_status_field_r == `CMR_MODE_NORMAL);
wire in_loop   = (op_mode_status_field_r == `CMR_MODE_LOOP);
wire wake_glitch_filter_en = bit_timing_cfg_c_r[`CMR_WAKE_GLITCH_FILTER_EN_BIT];
wire wake_enable = interrupt_enable_reg_r[`CMR_WAKE_ENABLE_BIT];

////////////////////////////////////////////////////////////////////////////
// axi4-lite slave: one write and one read in flight
reg        aw_got_r;
reg        w_got_r;
reg [7:0]  aw_addr_r;
reg [31:0] w_data_r;
reg [3:0]  w_strb_r;
assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
wire wr_go = aw_got_r && w_got_r;
wire wr_b0 = w_strb_r[0];
wire [7:0] wbyte = w_data_r[7:0];

reg wr_hit;
always @*
begin
  case (aw_addr_r)
    `CMR_OFF_CTRL, `CMR_OFF_STAT, `CMR_OFF_CFG_A, `CMR_OFF_CFG_B,
    `CMR_OFF_CFG_C, `CMR_OFF_TXRTS, `CMR_OFF_INTF, `CMR_OFF_INTE,
    `CMR_OFF_ERRCNT, `CMR_OFF_CMD, `CMR_OFF_FILT, `CMR_OFF_RXCTRL:
      wr_hit = 1'b1;
    default: wr_hit = 1'b0;
  endcase
end

// write effects; sleep blocks no writes, configuration registers need config mode
wire wr_ok  = wr_go && wr_b0;
wire cfg_wr = wr_ok && in_config;
wire wake_flag_set_sw = wr_ok && (aw_addr_r == `CMR_OFF_INTF) &&
                    wbyte[`CMR_WAKE_FLAG_BIT];

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_got_r     <= 1'b0;
    w_got_r      <= 1'b0;
    aw_addr_r    <= `CMR_ZERO8;
    w_data_r     <= 32'h00000000;
    w_strb_r     <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp  <= `CMR_AXI_OKAY;
  end
  else
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_r  <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_r  <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `CMR_AXI_OKAY : `CMR_AXI_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

reg [31:0] rd_mux;
reg        rd_hit;
always @*
begin
  rd_hit = 1'b1;
  rd_mux = 32'h00000000;
  case (s_axi_araddr)
    `CMR_OFF_CTRL:   rd_mux[7:0] = can_control_reg_r;
    `CMR_OFF_STAT:   rd_mux[7:5] = op_mode_status_field_r;
    `CMR_OFF_CFG_A:  rd_mux[7:0] = bit_timing_cfg_a_r;
    `CMR_OFF_CFG_B:  rd_mux[7:0] = bit_timing_cfg_b_r;
    `CMR_OFF_CFG_C:  rd_mux[7:0] = bit_timing_cfg_c_r;
    `CMR_OFF_TXRTS:  rd_mux[7:0] = tx_request_pin_ctrl_r;
    `CMR_OFF_INTF:   rd_mux[7:0] = interrupt_flag_reg_r;
    `CMR_OFF_INTE:   rd_mux[7:0] = interrupt_enable_reg_r;
    `CMR_OFF_ERRCNT: rd_mux[15:0] = {rec_r, tec_r};
    `CMR_OFF_CMD:    rd_mux = 32'h00000000;
    `CMR_OFF_FILT:   rd_mux = filter_mask_r;
    `CMR_OFF_RXCTRL: rd_mux[7:0] = rx_buffer_ctrl_r;
    default:         rd_hit = 1'b0;
  endcase
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata  <= 32'h00000000;
    s_axi_rresp  <= `CMR_AXI_OKAY;
  end
  else if (s_axi_arvalid && s_axi_arready)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rdata  <= rd_mux;
    s_axi_rresp  <= rd_hit ? `CMR_AXI_OKAY : `CMR_AXI_SLVERR;
  end
  else if (s_axi_rvalid && s_axi_rready)
    s_axi_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// sleep receive filter and bus activity detection
wire rx_seen = wake_glitch_filter_en ? rx_filt_r : rx_s;
wire bus_activity = rx_prev_r && !rx_seen;

always @(posedge aclk)
begin
  if (int_rst)
  begin
    filt_cnt_r <= 4'd0;
    rx_filt_r  <= 1'b1;
    rx_prev_r  <= 1'b1;
  end
  else
  begin
    rx_prev_r <= rx_seen;
    if (rx_s == rx_filt_r)
      filt_cnt_r <= 4'd0;
    else if (filt_cnt_r == `CMR_FILT_CYC - 4'd1)
    begin
      filt_cnt_r <= 4'd0;
      rx_filt_r  <= rx_s;
    end
    else
      filt_cnt_r <= filt_cnt_r + 4'd1;
  end
end

////////////////////////////////////////////////////////////////////////////
// mode state machine and control registers
wire sleeping = (state_r == ST_SLEEP);
wire wake_ev  = sleeping && (bus_activity || wake_flag_set_sw);

always @(posedge aclk)
begin
  if (int_rst)
  begin
    state_r                <= ST_RUN;
    can_control_reg_r      <= `CMR_CTRL_RST;
    op_mode_status_field_r <= `CMR_MODE_CONFIG;
    bit_timing_cfg_a_r     <= `CMR_ZERO8;
    bit_timing_cfg_b_r     <= `CMR_ZERO8;
    bit_timing_cfg_c_r     <= `CMR_ZERO8;
    tx_request_pin_ctrl_r  <= `CMR_ZERO8;
    interrupt_flag_reg_r   <= `CMR_ZERO8;
    interrupt_enable_reg_r <= `CMR_ZERO8;
    filter_mask_r          <= 32'h00000000;
    rx_buffer_ctrl_r       <= `CMR_ZERO8;
    osc_startup_timer_r    <= `CMR_ZERO8;
    discard_r              <= 1'b0;
    soft_reset_r           <= 1'b0;
  end
  else
  begin
    soft_reset_r <= wr_ok && (aw_addr_r == `CMR_OFF_CMD) &&
                    wbyte[`CMR_RESET_BIT];
    if (wr_ok && aw_addr_r == `CMR_OFF_CTRL)
      can_control_reg_r <= wbyte;
    if (wr_ok && aw_addr_r == `CMR_OFF_INTE)
      interrupt_enable_reg_r <= wbyte;
    if (wr_ok && aw_addr_r == `CMR_OFF_RXCTRL)
      rx_buffer_ctrl_r <= wbyte;
    if (cfg_wr && aw_addr_r == `CMR_OFF_CFG_A)
      bit_timing_cfg_a_r <= wbyte;
    if (cfg_wr && aw_addr_r == `CMR_OFF_CFG_B)
      bit_timing_cfg_b_r <= wbyte;
    if (cfg_wr && aw_addr_r == `CMR_OFF_CFG_C)
      bit_timing_cfg_c_r <= wbyte;
    if (cfg_wr && aw_addr_r == `CMR_OFF_TXRTS)
      tx_request_pin_ctrl_r <= wbyte;
    if (cfg_wr && aw_addr_r == `CMR_OFF_FILT)
      filter_mask_r <= w_data_r;
    // software write of flags; wake event wins over a clear
    if (wr_ok && aw_addr_r == `CMR_OFF_INTF)
      interrupt_flag_reg_r <= wbyte;
    if (wake_ev && wake_enable)
      interrupt_flag_reg_r[`CMR_WAKE_FLAG_BIT] <= 1'b1;
    if (rx_frame_done)
      discard_r <= 1'b0;
    case (state_r)
      ST_RUN:
      begin
        // change only once pending transmissions have drained
        if (req_valid && !tx_pending &&
            mode_request_field != op_mode_status_field_r)
        begin
          if (mode_request_field == `CMR_MODE_SLEEP)
          begin
            state_r                <= ST_SLEEP;
            op_mode_status_field_r <= `CMR_MODE_SLEEP;
          end
          else
            op_mode_status_field_r <= mode_request_field;
        end
      end
      ST_SLEEP:
      begin
        if (wake_ev)
        begin
          state_r             <= ST_WAKE;
          osc_startup_timer_r <= `CMR_OST_CYC;
          discard_r           <= 1'b1;
        end
      end
      ST_WAKE:
      begin
        if (osc_startup_timer_r == 8'd1)
        begin
          state_r                <= ST_RUN;
          op_mode_status_field_r <= `CMR_MODE_LISTEN;
          can_control_reg_r[`CMR_REQ_HI:`CMR_REQ_LO] <= `CMR_MODE_LISTEN;
        end
        osc_startup_timer_r <= osc_startup_timer_r - 8'd1;
      end
      default: state_r <= ST_RUN;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// error counters
always @(posedge aclk)
begin
  if (int_rst || in_config || in_listen)
  begin
    tec_r <= `CMR_ZERO8;
    rec_r <= `CMR_ZERO8;
  end
  else if (in_normal || in_loop)
  begin
    if (tec_inc && tec_r != 8'hFF)
      tec_r <= tec_r + 8'd1;
    if (rec_inc && rec_r != 8'hFF)
      rec_r <= rec_r + 8'd1;
  end
end

////////////////////////////////////////////////////////////////////////////
// pin and engine outputs
always @(posedge aclk)
begin
  if (int_rst)
  begin
    bus_tx_out   <= 1'b1;
    rx_accept_en <= 1'b0;
    loopback_en  <= 1'b0;
    ack_ignore   <= 1'b0;
    osc_run      <= 1'b1;
    wake_irq     <= 1'b0;
  end
  else
  begin
    // only normal mode drives the bus; all else recessive
    bus_tx_out   <= (state_r == ST_RUN && in_normal) ?
                    engine_tx_bit : 1'b1;
    rx_accept_en <= (state_r == ST_RUN) && !discard_r &&
                    !in_config;
    loopback_en  <= in_loop && state_r == ST_RUN;
    ack_ignore   <= in_loop;
    osc_run      <= !sleeping;
    wake_irq     <= interrupt_flag_reg_r[`CMR_WAKE_FLAG_BIT] &&
                    wake_enable;
  end
end

endmodule
`default_nettype wire

// >>> tb/cmr_mode_ctrl_props.sv
// port-level assertions for the mode and reset controller
`timescale 1ns/1ps
`default_nettype none
module cmr_mode_ctrl_props (
  // clock and resets
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        reset_pin_n,
  // register bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // mode outputs
  input wire logic        bus_tx_out,
  input wire logic        rx_accept_en,
  input wire logic        loopback_en,
  input wire logic        ack_ignore,
  input wire logic        osc_run,
  input wire logic        wake_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////
  sequence s_asleep;
    !osc_run ##1 !osc_run;
  endsequence
  sequence s_pin_held;
    !reset_pin_n [*5];
  endsequence
  sequence s_looping;
    loopback_en ##1 loopback_en;
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_rst_defaults: assert property (
    $rose(aresetn) |-> bus_tx_out && osc_run && !loopback_en && !wake_irq)
    else $error("outputs not at reset values after reset");
  a_pin_reset: assert property (
    s_pin_held |-> bus_tx_out && osc_run && !loopback_en && !wake_irq)
    else $error("reset pin did not reset the outputs");
  a_sleep_tx_idle: assert property (s_asleep |-> bus_tx_out)
    else $error("transmit pin dominant during sleep");
  a_sleep_no_rx: assert property (
    s_asleep |-> !rx_accept_en && !loopback_en)
    else $error("reception enabled during sleep");
  a_loop_ack_pair: assert property (loopback_en == ack_ignore)
    else $error("ack ignore differs from loopback");
  a_loop_tx_quiet: assert property (s_looping |-> bus_tx_out)
    else $error("transmit pin dominant in loopback");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_aw_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule
bind cmr_mode_ctrl cmr_mode_ctrl_props chk_u (
  .aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .bus_tx_out(bus_tx_out),
  .rx_accept_en(rx_accept_en), .loopback_en(loopback_en),
  .ack_ignore(ack_ignore), .osc_run(osc_run), .wake_irq(wake_irq));
`default_nettype wire

// >>> tb/cmr_can_node.sv
// far bus node: sends one short frame, bit time 400 ns
`timescale 1ns/1ps
`default_nettype none
module cmr_can_node (
  // trigger from the bench
  input  wire logic send,
  // bus line, pulled up to recessive when released
  output var  logic rx
);
  logic [7:0] pat;
  initial rx = 1'h1;
  always @(posedge send)
  begin
    pat = 8'h5A;
    #7;
    repeat (8)
    begin
      rx = pat[7];
      pat = pat << 1;
      #400;
    end
    rx = 1'h1;
  end
endmodule
`default_nettype wire

// >>> tb/cmr_mode_ctrl_tb_top.sv
// bench for the mode and reset controller
`timescale 1ns/1ps
`default_nettype none
module cmr_mode_ctrl_tb_top;
  logic        aclk = 1'h0, aresetn = 1'h0, pin_n = 1'h1;
  logic        awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic        txp = 1'h0, tec = 1'h0, rec = 1'h0, send = 1'h0, rfd = 1'h0;
  logic        awr, wrdy, bv, arr, rv, tx, acc, lpb, ack, osc, wirq, rxl;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0]  br, rr, rsp;
  int          failures = 0, compares = 0, cyc = 0;
  always #25 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  cmr_can_node node_u (.send(send), .rx(rxl));
  cmr_mode_ctrl dut_u (
    .aclk(aclk), .aresetn(aresetn), .reset_pin_n(pin_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .bus_rx_in(rxl),
    .bus_tx_out(tx), .tx_pending(txp), .engine_tx_bit(1'h0),
    .tec_inc(tec), .rec_inc(rec), .rx_frame_done(rfd),
    .rx_accept_en(acc), .loopback_en(lpb), .ack_ignore(ack),
    .osc_run(osc), .wake_irq(wirq));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // handshakes are judged on the falling edge, acted on at the rising one;
  // one idle edge first keeps a release and the next request apart
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [1:0] er);
    logic ta, tw, tb, fin;
    logic [1:0] rs;
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    fin = 1'h0;
    while (!fin)
    begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv;
      rs = br;
      @(posedge aclk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      if (tb) bre <= 1'h0;
      fin = tb;
    end
    chk("write response", {30'h0, er}, {30'h0, rs});
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tr, fin;
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    fin = 1'h0;
    while (!fin)
    begin
      @(negedge aclk);
      ta = arv && arr;
      tr = rv;
      d = rdat;
      rsp = rr;
      @(posedge aclk);
      if (ta) arv <= 1'h0;
      if (tr) rre <= 1'h0;
      fin = tr;
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] d;
    bus_rd(a, d);
    chk(nm, e, d);
    chk("read response", 32'h0, {30'h0, rsp});
  endtask
  task automatic set_mode(input logic [2:0] m);
    bus_wr(8'h00, {m, 5'h07}, 2'h0);
  endtask
  task automatic see_mode(input logic [2:0] m);
    logic [31:0] d;
    bus_rd(8'h04, d);
    chk("mode status", {29'h0, m}, {29'h0, d[7:5]});
  endtask
  task automatic pulse(input int nt, input int nr);
    for (int i = 0; i < 3; i++)
    begin
      tec <= (i < nt);
      rec <= (i < nr);
      @(posedge aclk);
      tec <= 1'h0;
      rec <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task automatic wait_wake(input int t0);
    logic [31:0] d;
    d = 32'h0;
    while (d[7:5] !== 3'h3 && cyc - t0 < 400)
      bus_rd(8'h04, d);
    chk("wake delay", 32'h1, {31'h0, cyc - t0 >= 128 && cyc - t0 <= 150});
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    logic [2:0] req [7] = '{3'h2, 3'h3, 3'h0, 3'h5, 3'h6, 3'h7, 3'h4};
    logic [2:0] want [7] = '{3'h2, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
    for (int i = 0; i < 7; i++)
    begin
      set_mode(req[i]);
      see_mode(want[i]);
      chk("loopback", {31'h0, want[i] == 3'h2}, {31'h0, lpb});
      chk("ack ignore", {31'h0, want[i] == 3'h2}, {31'h0, ack});
      chk("tx pin", {31'h0, want[i] != 3'h0}, {31'h0, tx});
      chk("rx accept", {31'h0, want[i] != 3'h4}, {31'h0, acc});
    end
    $display("mode table test done");
  endtask
  task automatic t_pending;
    txp <= 1'h1;
    set_mode(3'h0);
    repeat (4) @(posedge aclk);
    see_mode(3'h4);
    txp <= 1'h0;
    repeat (3) @(posedge aclk);
    see_mode(3'h0);
    $display("pending transmit test done");
  endtask
  task automatic t_cfg;
    logic [31:0] d;
    bus_wr(8'h08, 8'h5A, 2'h0);
    rd_chk("timing a locked", 8'h08, 32'h0);
    set_mode(3'h4);
    bus_wr(8'h08, 8'h5A, 2'h0);
    rd_chk("timing a open", 8'h08, 32'h5A);
    bus_wr(8'h40, 8'h01, 2'h2);
    bus_rd(8'h40, d);
    chk("unmapped read response", 32'h2, {30'h0, rsp});
    $display("config lock test done");
  endtask
  task automatic t_err;
    set_mode(3'h0);
    pulse(3, 2);
    rd_chk("error counts", 8'h20, 32'h0203);
    set_mode(3'h4);
    rd_chk("counts in config", 8'h20, 32'h0);
    set_mode(3'h0);
    pulse(1, 1);
    set_mode(3'h3);
    rd_chk("counts listen", 8'h20, 32'h0);
    pulse(2, 2);
    rd_chk("counts frozen", 8'h20, 32'h0);
    $display("error counter test done");
  endtask
  task automatic t_sleep;
    int t0;
    set_mode(3'h4);
    bus_wr(8'h10, 8'h40, 2'h0);
    set_mode(3'h0);
    set_mode(3'h1);
    see_mode(3'h1);
    chk("osc run", 32'h0, {31'h0, osc});
    chk("tx sleep", 32'h1, {31'h0, tx});
    rd_chk("cfg c asleep", 8'h10, 32'h40);
    t0 = cyc;
    send <= 1'h1;
    wait_wake(t0);
    send <= 1'h0;
    rd_chk("request after wake", 8'h00, 32'h67);
    chk("accept in wake window", 32'h0, {31'h0, acc});
    rfd <= 1'h1;
    @(posedge aclk);
    rfd <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("accept in listen", 32'h1, {31'h0, acc});
    set_mode(3'h0);
    see_mode(3'h0);
    bus_wr(8'h1C, 8'h40, 2'h0);
    set_mode(3'h1);
    t0 = cyc;
    bus_wr(8'h18, 8'h40, 2'h0);
    wait_wake(t0);
    chk("wake irq", 32'h1, {31'h0, wirq});
    $display("sleep and wake test done");
  endtask
  task automatic t_reset(input logic pin);
    set_mode(3'h0);
    if (pin)
    begin
      pin_n <= 1'h0;
      repeat (5) @(posedge aclk);
      pin_n <= 1'h1;
    end
    else
      bus_wr(8'h24, 8'h01, 2'h0);
    repeat (6) @(posedge aclk);
    see_mode(3'h4);
    rd_chk("control reset", 8'h00, 32'hE7);
    $display("reset test done");
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_modes();
    t_pending();
    t_cfg();
    t_err();
    t_sleep();
    t_reset(1'h0);
    t_reset(1'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
